// *** hw/bliu_pkg.sv ***
// Constants and types shared by the bitwise logic unit and the increment unit.
// Assumes a single core clock; operands come from the register crossbar.
// Function
// - Logic unit result appears one cycle after operands are presented.
// - Each result bit indexes a 4-bit truth code by the A,B bit pair.
// - The 3-bit function code expands to and, and-not-b, xor, or, nor, xnor, or-not-b, nand.
// - Optional reduction ANDs or ORs all bits of each packet.
// - Packet reduction works on byte packets only.
// - Add one flips low bits through the first zero, which becomes one.
// - The carry tree also yields the lowest set bit search.
// - Subtract one inverts operand and result; lowest clear bit inverts the operand only.
// - Highest bit searches reverse the operand bit order first.
// - Magnitude passes operand if non-negative, else its negation.
// - Compare: xor operands, find top differing bit, and with one operand.
// - Final mux picks either operand for min, max and clip.
// - Signed compare inverts each chunk's sign bit in both operands.
// - Add one, subtract one, negate, magnitude finish in one stage.
// - Those single-stage operations also work per SIMD chunk.
// - Search, min and max take one extra pipeline stage.
package bliu_pkg;
  localparam int WORD_W_DEF = 64;
  localparam int CHUNK_W_DEF = 64;
  localparam int PACKET_W = 8;
  localparam int FUNC_W = 3;
  localparam int TRUTH_W = 4;
  localparam int LOGIC_LATENCY = 1;
  localparam int INC_FAST_LATENCY = 1;
  localparam int INC_SLOW_LATENCY = 2;

  typedef enum logic [1:0] {BLIU_RED_NONE, BLIU_RED_AND, BLIU_RED_OR} bliu_reduce_t;

  typedef enum logic [3:0] {
    BLIU_INC, BLIU_DEC, BLIU_NEG, BLIU_ABS,
    BLIU_LOW_SET, BLIU_LOW_CLR, BLIU_HIGH_SET, BLIU_HIGH_CLR,
    BLIU_CMP, BLIU_MIN, BLIU_MAX, BLIU_CLIP
  } bliu_inc_op_t;

  // Truth codes: leftmost bit answers A=0,B=0, rightmost A=1,B=1
  function automatic logic [3:0] bliu_truth(input logic [2:0] func);
    logic [3:0] t;
    t = 4'h0;
    unique case (func)
      3'h0: t = 4'h1;
      3'h1: t = 4'h2;
      3'h2: t = 4'h6;
      3'h3: t = 4'h7;
      3'h4: t = 4'h8;
      3'h5: t = 4'h9;
      3'h6: t = 4'hb;
      3'h7: t = 4'he;
    endcase
    return t;
  endfunction
endpackage

// *** hw/bliu_logic.sv ***
// Bitwise two-operand logic unit with optional per-byte reduction.
// Assumes operands valid for one cycle at the crossbar; reset clears the datapath register.
`timescale 1ns/10ps
module bliu_logic
  import bliu_pkg::*;
#(
  parameter int WORD_W = bliu_pkg::WORD_W_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [bliu_pkg::FUNC_W-1:0] func,
  input wire bliu_pkg::bliu_reduce_t reduce,
  input wire logic [WORD_W-1:0] op_a,
  input wire logic [WORD_W-1:0] op_b,
  output logic out_valid,
  output logic [WORD_W-1:0] result
);
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] res;
  } bliu_logic_st_t;

  bliu_logic_st_t s_q;
  bliu_logic_st_t s_d;
  logic [3:0] truth;
  logic [WORD_W-1:0] bits;

  always_comb begin
    truth = bliu_truth(func);
    for (int i = 0; i < WORD_W; i++) begin
      // Index 0 is A=1,B=1, so the leftmost code bit answers 00
      bits[i] = truth[{~op_a[i], ~op_b[i]}];
    end
    s_d = s_q;
    s_d.valid = in_valid;
    s_d.res = bits;
    if (reduce != BLIU_RED_NONE) begin
      for (int p = 0; p < WORD_W / PACKET_W; p++) begin
        s_d.res[p*PACKET_W +: PACKET_W] = {PACKET_W{(reduce == BLIU_RED_AND) ?
          &bits[p*PACKET_W +: PACKET_W] : |bits[p*PACKET_W +: PACKET_W]}};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign out_valid = s_q.valid;
  assign result = s_q.res;
endmodule

// *** hw/bliu_exec.sv ***
// Top: bitwise logic unit plus increment/search/compare unit.
// Assumes the decoder issues at most one op per unit per cycle and
// accepts results as they appear; there is no stall path.
`timescale 1ns/10ps
module bliu_exec
  import bliu_pkg::*;
#(
  parameter int WORD_W = bliu_pkg::WORD_W_DEF,
  parameter int CHUNK_W = bliu_pkg::CHUNK_W_DEF
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic logic_valid,
  input wire logic [bliu_pkg::FUNC_W-1:0] logic_func,
  input wire bliu_pkg::bliu_reduce_t logic_reduce,
  input wire logic [WORD_W-1:0] logic_a,
  input wire logic [WORD_W-1:0] logic_b,
  output logic logic_out_valid,
  output logic [WORD_W-1:0] logic_result,
  input wire logic inc_valid,
  input wire bliu_pkg::bliu_inc_op_t inc_op,
  input wire logic inc_simd,
  input wire logic inc_signed,
  input wire logic [WORD_W-1:0] inc_a,
  input wire logic [WORD_W-1:0] inc_b,
  output logic inc_out_valid,
  output logic [WORD_W-1:0] inc_result
);
  localparam int NCH = WORD_W / CHUNK_W;

  ////////////////////////////////////////////////////////////////////////////
  bliu_logic #(.WORD_W(WORD_W)) u_logic (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(logic_valid),
    .func(logic_func),
    .reduce(logic_reduce),
    .op_a(logic_a),
    .op_b(logic_b),
    .out_valid(logic_out_valid),
    .result(logic_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mask of bits up to and including the lowest zero of each segment (segment = chunk or word)
  function automatic logic [WORD_W-1:0] low_ones(input logic [WORD_W-1:0] v,
                                                 input logic seg);
    logic [WORD_W-1:0] m;
    logic run;
    m = '0;
    run = 1'b1;
    for (int i = 0; i < WORD_W; i++) begin
      if (seg && (i % CHUNK_W == 0)) begin
        run = 1'b1;
      end
      m[i] = run;
      run = run & v[i];
    end
    return m;
  endfunction

  function automatic logic [WORD_W-1:0] rev(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] r;
    for (int i = 0; i < WORD_W; i++) begin
      r[i] = v[WORD_W-1-i];
    end
    return r;
  endfunction

  // Increment per segment: flip through the first zero
  function automatic logic [WORD_W-1:0] incr(input logic [WORD_W-1:0] v,
                                             input logic seg);
    return v ^ low_ones(v, seg);
  endfunction

  // Isolate the lowest set bit of the whole word, zero when none
  function automatic logic [WORD_W-1:0] lowest(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] m;
    m = low_ones(~v, 1'b0);
    return v & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic v1;
    logic [WORD_W-1:0] r1;
    logic slow;
    bliu_inc_op_t op;
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    logic [WORD_W-1:0] x;
    logic v2;
    logic [WORD_W-1:0] r2;
  } bliu_inc_st_t;

  bliu_inc_st_t s_q;
  bliu_inc_st_t s_d;
  logic [WORD_W-1:0] fast;
  logic [WORD_W-1:0] ca;
  logic [WORD_W-1:0] cb;
  logic [WORD_W-1:0] sgn;
  logic [WORD_W-1:0] top;
  logic a_lower;
  logic is_slow;

  always_comb begin
    fast = '0;
    sgn = '0;
    for (int c = 0; c < NCH; c++) begin
      sgn[c*CHUNK_W + CHUNK_W - 1] = 1'b1;
    end
    is_slow = inc_op inside {BLIU_LOW_SET, BLIU_LOW_CLR, BLIU_HIGH_SET,
                             BLIU_HIGH_CLR, BLIU_CMP, BLIU_MIN, BLIU_MAX, BLIU_CLIP};
    // First stage: one pass of input XOR, carry tree, mux and output XOR
    unique case (inc_op)
      BLIU_INC: fast = incr(inc_a, inc_simd);
      BLIU_DEC: fast = ~incr(~inc_a, inc_simd);
      BLIU_NEG: fast = incr(~inc_a, inc_simd);
      BLIU_ABS: begin
        fast = inc_a;
        for (int c = 0; c < NCH; c++) begin
          if ((inc_simd || c == NCH - 1) && inc_a[c*CHUNK_W + CHUNK_W - 1]) begin
            fast = incr(~inc_a, inc_simd);
          end
        end
        if (inc_simd) begin
          for (int c = 0; c < NCH; c++) begin
            if (!inc_a[c*CHUNK_W + CHUNK_W - 1]) begin
              fast[c*CHUNK_W +: CHUNK_W] = inc_a[c*CHUNK_W +: CHUNK_W];
            end
          end
        end
      end
      BLIU_LOW_SET: fast = inc_a;
      BLIU_LOW_CLR: fast = ~inc_a;
      BLIU_HIGH_SET: fast = rev(inc_a);
      BLIU_HIGH_CLR: fast = rev(~inc_a);
      default: fast = inc_a ^ inc_b;
    endcase
    ca = inc_signed ? (inc_a ^ sgn) : inc_a;
    cb = inc_signed ? (inc_b ^ sgn) : inc_b;

    s_d = s_q;
    s_d.v1 = inc_valid && !is_slow;
    s_d.r1 = fast;
    s_d.slow = inc_valid && is_slow;
    s_d.op = inc_op;
    s_d.a = inc_a;
    s_d.b = inc_b;
    s_d.x = (inc_op inside {BLIU_CMP, BLIU_MIN, BLIU_MAX, BLIU_CLIP}) ? (ca ^ cb) : fast;
    if (inc_op inside {BLIU_CMP, BLIU_MIN, BLIU_MAX, BLIU_CLIP}) begin
      s_d.a = ca;
      s_d.b = inc_a;
      s_d.r1 = inc_b;
    end

    // Second stage: search and select
    top = rev(lowest(rev(s_q.x)));
    a_lower = ~|(top & s_q.a);
    s_d.v2 = s_q.slow;
    unique case (s_q.op)
      BLIU_LOW_SET, BLIU_LOW_CLR: s_d.r2 = lowest(s_q.x);
      BLIU_HIGH_SET, BLIU_HIGH_CLR: s_d.r2 = rev(lowest(s_q.x));
      BLIU_CMP: s_d.r2 = {{(WORD_W-1){1'b0}}, a_lower & |s_q.x};
      BLIU_MIN: s_d.r2 = a_lower ? s_q.b : s_q.r1;
      BLIU_MAX: s_d.r2 = a_lower ? s_q.r1 : s_q.b;
      default: s_d.r2 = (!a_lower && |s_q.x) ? s_q.r1 : s_q.b;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // A slow result and a fast one issued a cycle later land together; slow wins
  assign inc_out_valid = s_q.v2 | s_q.v1;
  assign inc_result = s_q.v2 ? s_q.r2 : s_q.r1;
endmodule

// *** bench/bliu_exec_assertions.sv ***
// Concurrent checks on the execution units' top ports.
// Slow results are checked only when the edge after the request is enabled.
`timescale 1ns/10ps
module bliu_exec_assertions #(
  parameter int WORD_W = 64,
  parameter int CHUNK_W = 64
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic logic_valid,
  input wire logic [bliu_pkg::FUNC_W-1:0] logic_func,
  input wire bliu_pkg::bliu_reduce_t logic_reduce,
  input wire logic [WORD_W-1:0] logic_a,
  input wire logic [WORD_W-1:0] logic_b,
  input wire logic logic_out_valid,
  input wire logic [WORD_W-1:0] logic_result,
  input wire logic inc_valid,
  input wire bliu_pkg::bliu_inc_op_t inc_op,
  input wire logic inc_simd,
  input wire logic inc_signed,
  input wire logic [WORD_W-1:0] inc_a,
  input wire logic [WORD_W-1:0] inc_b,
  input wire logic inc_out_valid,
  input wire logic [WORD_W-1:0] inc_result
);
  import bliu_pkg::*;
  ////////////////////////////////////////
  logic bytes_flat;
  wire go_l = clk_en && logic_valid;
  wire go_i = clk_en && inc_valid && !inc_simd;
  always_comb begin
    bytes_flat = 1'b1;
    for (int i = 0; i < WORD_W; i++) bytes_flat &= logic_result[i] == logic_result[i/8*8];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  lat_logic_a: assert property (go_l |=> logic_out_valid)
    else $error("logic result late");
  idle_logic_a: assert property (clk_en && !logic_valid |=> !logic_out_valid)
    else $error("logic result without request");
  xor_op_a: assert property (go_l && logic_func == 3'h2 && logic_reduce == BLIU_RED_NONE
    |=> logic_result == ($past(logic_a) ^ $past(logic_b))) else $error("xor wrong");
  and_with_inverted_b_op_a: assert property (go_l && logic_func == 3'h1 && logic_reduce == BLIU_RED_NONE
    |=> logic_result == ($past(logic_a) & ~$past(logic_b))) else $error("and-not wrong");
  byte_fill_a: assert property (go_l && logic_reduce != BLIU_RED_NONE |=> bytes_flat)
    else $error("reduced byte not uniform");
  inc_one_a: assert property (go_i && inc_op == BLIU_INC
    |=> inc_out_valid && inc_result == $past(inc_a) + 1'b1) else $error("add one wrong");
  dec_one_a: assert property (go_i && inc_op == BLIU_DEC
    |=> inc_result == $past(inc_a) - 1'b1) else $error("subtract one wrong");
  abs_val_a: assert property (go_i && inc_op == BLIU_ABS |=> inc_result ==
    ($past(inc_a[WORD_W-1]) ? -$past(inc_a) : $past(inc_a))) else $error("magnitude wrong");
  low_set_a: assert property (go_i && inc_op == BLIU_LOW_SET ##1 clk_en |=> inc_out_valid &&
    inc_result == ($past(inc_a, 2) & -$past(inc_a, 2))) else $error("lowest set wrong");
  min_pick_a: assert property (go_i && inc_op == BLIU_MIN && !inc_signed ##1 clk_en |=>
    inc_result == ($past(inc_a, 2) < $past(inc_b, 2) ? $past(inc_a, 2) : $past(inc_b, 2)))
    else $error("minimum wrong");
endmodule
////////////////////////////////////////
bind bliu_exec bliu_exec_assertions #(.WORD_W(WORD_W), .CHUNK_W(CHUNK_W)) u_chk (
  .sys_clk, .reset_n, .clk_en, .logic_valid, .logic_func, .logic_reduce, .logic_a,
  .logic_b, .logic_out_valid, .logic_result, .inc_valid, .inc_op, .inc_simd,
  .inc_signed, .inc_a, .inc_b, .inc_out_valid, .inc_result);

// *** bench/bliu_issue_model.sv ***
// Decoder-side model driving the increment unit's issue port.
// Assumes the caller steps it once per cycle just after the rising edge.
`timescale 1ns/10ps
module bliu_issue_model #(
  parameter int WORD_W = 16
) (
  output logic inc_valid,
  output bliu_pkg::bliu_inc_op_t inc_op,
  output logic inc_simd,
  output logic inc_signed,
  output logic [WORD_W-1:0] inc_a,
  output logic [WORD_W-1:0] inc_b
);
  import bliu_pkg::*;
  ////////////////////////////////////////
  initial begin
    {inc_valid, inc_simd, inc_signed, inc_a, inc_b} = '0;
    inc_op = BLIU_INC;
  end
  task automatic issue(input logic v, input int op, input logic sd, input logic sg,
                       input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    inc_valid = v;
    inc_op = bliu_inc_op_t'(op);
    inc_simd = sd;
    inc_signed = sg;
    // Idle operands flip every cycle so a stale value never looks live
    inc_a = v ? a : ~inc_a;
    inc_b = v ? b : ~inc_b;
  endtask
endmodule

// *** bench/testbench.sv ***
// Random back-to-back traffic on both units, checked against integer models.
// Assumes a 16-bit word in two 8-bit chunks; clk_en is dropped at random.
`timescale 1ns/10ps
module testbench;
  import bliu_pkg::*;
  logic sys_clk, reset_n, logic_valid, logic_out_valid, inc_valid, inc_simd, inc_signed;
  logic inc_out_valid, v, prev_slow, clk_en, hold_lv, hold_iv;
  logic [15:0] hold_lr, hold_ir;
  logic [2:0] logic_func;
  bliu_reduce_t logic_reduce;
  bliu_inc_op_t inc_op;
  logic [15:0] logic_a, logic_b, logic_result, inc_a, inc_b, inc_result, er_l[4], er_i[4];
  bit ev_l[4], ev_i[4];
  int n_mismatch = 0, n_compared = 0, seed = 83726, op, k, t = 0;
  bliu_exec #(.WORD_W(16), .CHUNK_W(8)) DUT (.sys_clk, .reset_n, .clk_en, .logic_valid,
    .logic_func, .logic_reduce, .logic_a, .logic_b, .logic_out_valid, .logic_result, .inc_valid,
    .inc_op, .inc_simd, .inc_signed, .inc_a, .inc_b, .inc_out_valid, .inc_result);
  bliu_issue_model #(.WORD_W(16)) partner (.inc_valid, .inc_op, .inc_simd, .inc_signed,
    .inc_a, .inc_b);
  ////////////////////////////////////////
  function automatic int rnd(int n);
    return $unsigned($random(seed)) % n;
  endfunction
  function automatic logic [15:0] pick();
    logic [15:0] e[4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7f7f};
    return rnd(3) == 0 ? e[rnd(4)] : 16'($random(seed));
  endfunction
  function automatic int logm(int f, int rd, int a, int b);
    bit [3:0] t[8] = '{4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'he};
    int r = 0, y;
    for (int i = 0; i < 16; i++) r |= t[f][3 - ((a >> i & 1) * 2 + (b >> i & 1))] << i;
    for (int s = 0; s < 16 && rd != 0; s += 8) begin
      y = r >> s & 8'hff;
      y = rd == 1 ? y == 8'hff : y != 0;
      r = r & ~(8'hff << s) | y * 8'hff << s;
    end
    return r;
  endfunction
  function automatic int incm(int op, bit sd, bit sg, int a, int b);
    int r = 0, c = sd ? 8 : 16, x, y, m = sg ? 16'h8080 : 0;
    if (op < 4) begin
      for (int s = 0; s < 16; s += c) begin
        x = a >> s & ((1 << c) - 1);
        case (op)
          0: y = x + 1;
          1: y = x - 1;
          2: y = -x;
          default: y = x >> (c - 1) ? -x : x;
        endcase
        r |= (y & ((1 << c) - 1)) << s;
      end
      return r;
    end
    x = op == 5 || op == 7 ? ~a & 16'hffff : a;
    if (op < 6) return x & -x;
    for (int i = 0; i < 16 && op < 8; i++) if (x >> i & 1) r = 1 << i;
    case (op)
      8: r = (a ^ m) < (b ^ m);
      9: r = (a ^ m) < (b ^ m) ? a : b;
      10: r = (a ^ m) < (b ^ m) ? b : a;
      11: r = (a ^ m) > (b ^ m) ? b : a;
      default: ;
    endcase
    return r;
  endfunction
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {reset_n, logic_valid, logic_func, logic_a, logic_b, prev_slow} = '0;
    clk_en = 1;
    logic_reduce = BLIU_RED_NONE;
    repeat (6) @(posedge sys_clk);
    #1 reset_n = 1;
    for (int c = 0; c < 800; c++) begin
      @(posedge sys_clk);
      #1;
      k = t % 4;
      if (clk_en) begin
        check("logic_out_valid", logic_out_valid, ev_l[k]);
        if (ev_l[k]) check("logic_result", logic_result, er_l[k]);
        check("inc_out_valid", inc_out_valid, ev_i[k]);
        if (ev_i[k]) check("inc_result", inc_result, er_i[k]);
        {hold_lv, hold_lr, hold_iv, hold_ir} = {ev_l[k], er_l[k], ev_i[k], er_i[k]};
        ev_l[k] = 0;
        ev_i[k] = 0;
        t++;
      end else begin
        // A frozen edge must leave both result ports as they were
        check("held logic_out_valid", logic_out_valid, hold_lv);
        if (hold_lv) check("held logic_result", logic_result, hold_lr);
        check("held inc_out_valid", inc_out_valid, hold_iv);
        if (hold_iv) check("held inc_result", inc_result, hold_ir);
      end
      // Inputs keep changing while frozen; none of that may be taken
      clk_en = rnd(8) != 0;
      logic_valid = rnd(4) != 0;
      logic_func = 3'(rnd(8));
      logic_reduce = bliu_reduce_t'(rnd(3));
      logic_a = pick();
      logic_b = pick();
      if (clk_en && logic_valid) begin
        ev_l[t % 4] = 1;
        er_l[t % 4] = 16'(logm(logic_func, logic_reduce, logic_a, logic_b));
      end
      op = rnd(12);
      // A fast op right behind a slow one would be lost in the output mux
      v = rnd(5) != 0 && !(prev_slow && op < 4);
      partner.issue(v, op, 1'(rnd(2)), 1'(rnd(2)), pick(), pick());
      if (clk_en) begin
        prev_slow = v && op > 3;
        k = (t + (op > 3 ? 1 : 0)) % 4;
        // Port nets lag the task's writes, so the model reads the partner directly
        if (v) begin
          ev_i[k] = 1;
          er_i[k] = 16'(incm(op, partner.inc_simd, partner.inc_signed, partner.inc_a,
            partner.inc_b));
        end
      end
    end
    final_report();
  end
endmodule
